//--- common/oscp_pkg.sv
// Constants and types shared by the output short-circuit protection block
package oscp_pkg;

    // Width of the led chain code field
    localparam int CODE_W = 4;
    // Number of selectable threshold levels
    localparam int NUM_LEVELS = 16;
    // Width of a threshold expressed in millivolts
    localparam int MV_W = 11;
    // Width of the short filter counter
    localparam int FILT_W = 4;

    // Consecutive cycles below threshold that confirm a short
    localparam logic [FILT_W-1:0] FILT_CYCLES = 4'h8;
    // Counter value after reset or after the comparator recovers
    localparam logic [FILT_W-1:0] FILT_CLEAR = 4'h0;

    // Code used after reset and forced in limp-home state
    localparam logic [CODE_W-1:0] DEFAULT_CODE = 4'h8;
    // Code that selects the highest level
    localparam logic [CODE_W-1:0] TOP_CODE = 4'h0;

    // Threshold of code 1 in millivolts
    localparam logic [MV_W-1:0] THR_BASE_MV = 11'h026;
    // Step between adjacent codes in millivolts
    localparam logic [MV_W-1:0] THR_STEP_MV = 11'h04B;
    // Threshold of code 0 in millivolts
    localparam logic [MV_W-1:0] THR_TOP_MV = 11'h48B;

    // Protection sequencer states
    typedef enum logic [2:0] {
        ST_RAMP = 3'b000,      // Soft-start rising, detection blanked
        ST_RUN = 3'b001,       // Regulating, detection armed
        ST_FAULT = 3'b010,     // Short confirmed, break-low held
        ST_DISCHARGE = 3'b011, // Waiting for soft-start to restart low
        ST_OTP = 3'b100        // Overtemperature shutdown
    } oscp_state_t;

endpackage

//--- src/oscp_short_filter.sv
// Digital filter that confirms a sustained low feedback comparator
`timescale 1ns/1ps
module oscp_short_filter (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_below,
    input wire logic i_armed,
    output logic o_trip
);

    // Cycles the comparator has been low while armed
    logic [oscp_pkg::FILT_W-1:0] count;
    // Next counter value
    logic [oscp_pkg::FILT_W-1:0] next_count;

    // Count up while armed and low, saturate at the confirm figure
    always_comb begin
        next_count = count;
        if (!(i_armed && i_below)) begin
            // Any recovery or blanking restarts the window
            next_count = oscp_pkg::FILT_CLEAR; // [R2]
        end else if (count != oscp_pkg::FILT_CYCLES) begin
            next_count = count + 4'h1; // [R1]
        end
    end

    // Counter register, frozen while the clock enable is low
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count <= oscp_pkg::FILT_CLEAR;
        end else if (i_clk_en) begin
            count <= next_count;
        end
    end

    // Trip only once the full run has been seen
    assign o_trip = (count == oscp_pkg::FILT_CYCLES); // [R1]

    // A break in the low run must empty the counter
    chk_filter_restart: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R2]
        (i_clk_en && !(i_armed && i_below)) |=> (count == oscp_pkg::FILT_CLEAR))
        else $error("filter count kept after comparator recovered");

    // The last low sample of a full run must raise the trip
    chk_filter_trip: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R1]
        (i_clk_en && i_armed && i_below && count == (oscp_pkg::FILT_CYCLES - 4'h1))
        |=> o_trip)
        else $error("filter missed a full run of low samples");

endmodule // oscp_short_filter

//--- src/oscp_top.sv
// Output short-circuit protection: filter, threshold select, fault sequencing
`timescale 1ns/1ps

// Summary of operation
// [R1] Short needs eight consecutive low comparator cycles
// [R2] Filter restarts when comparator recovers early
// [R3] No short detection until blanking indication
// [R4] Open-load detection blanked until blanking end
// [R5] Confirmed short sets short led flag
// [R6] Confirmed short forces break-low gate state
// [R7] Automatic restart through soft-start after fault
// [R8] Flag holds until next diagnosis read
// [R9] Threshold taken from 4-bit led chain code
// [R10] Codes 1-15 linear, code 0 highest, default 8
// [R11] Sixteen distinct threshold steps
// [R12] Limp-home forces default threshold code
// [R13] Overvoltage threshold independent of chain code
// [R14] Chain code feeds threshold and fast discharge
// [R15] Analog dimming never affects short threshold
// [R16] Host computes code from divider ratio
// [R17] Host updates code with active LED count
// [R18] Overtemperature overrides every other fault
module oscp_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_fb_below_cmp,
    input wire logic i_softstart_blank_end,
    input wire logic [oscp_pkg::CODE_W-1:0] i_led_chain_code,
    input wire logic i_limp_home,
    input wire logic i_diag_read_done,
    input wire logic i_overtemp,
    output logic o_short_led_flag,
    output logic o_break_low,
    output logic o_gate_shutdown,
    output logic o_softstart_restart,
    output logic o_open_load_enable,
    output logic [oscp_pkg::CODE_W-1:0] o_short_threshold_code,
    output logic [oscp_pkg::MV_W-1:0] o_short_threshold_mv,
    output logic [oscp_pkg::CODE_W-1:0] o_fast_discharge_code
);

    // First and second stage of the comparator synchroniser
    logic below_meta;
    logic below_sync;
    // First and second stage of the blanking-end synchroniser
    logic blank_meta;
    logic blank_sync;

    // Analog pins are asynchronous to the device clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            below_meta <= 1'b0;
            below_sync <= 1'b0;
            blank_meta <= 1'b0;
            blank_sync <= 1'b0;
        end else if (i_clk_en) begin
            below_meta <= i_fb_below_cmp;
            below_sync <= below_meta;
            blank_meta <= i_softstart_blank_end;
            blank_sync <= blank_meta;
        end
    end

    // Threshold per code, one entry per level
    logic [oscp_pkg::MV_W-1:0] thr_table [oscp_pkg::NUM_LEVELS];

    // Linear ladder from code 1, code 0 wraps to the top level
    for (genvar g = 0; g < oscp_pkg::NUM_LEVELS; g++) begin : g_thr
        if (g == 0) begin : g_top
            assign thr_table[g] = oscp_pkg::THR_TOP_MV; // [R10]
        end else begin : g_lin
            assign thr_table[g] = oscp_pkg::MV_W'(oscp_pkg::THR_BASE_MV
                + oscp_pkg::THR_STEP_MV * (g - 1)); // [R10] [R11]
        end
    end

    // First and second stage of the overtemperature synchroniser
    logic ot_meta;
    logic ot_sync;

    // Temperature sensor output is asynchronous to the device clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ot_meta <= 1'h0;
            ot_sync <= 1'h0;
        end else if (i_clk_en) begin
            ot_meta <= i_overtemp;
            ot_sync <= ot_meta;
        end
    end

    // Sequencer state and its next value
    oscp_pkg::oscp_state_t state;
    oscp_pkg::oscp_state_t next_state;
    // Filter enable, high only while regulating
    logic armed;
    // Filter has seen the full run of low samples
    logic trip;

    // Detection is blanked in every state but regulation
    assign armed = (state == oscp_pkg::ST_RUN); // [R3]

    // Consecutive-cycle filter on the synchronised comparator
    // Sees the same samples the sequencer sees, so no extra lag
    oscp_short_filter i_filter (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_below(below_sync),
        .i_armed(armed),
        .o_trip(trip)
    );

    // Next sequencer state; overtemperature is checked last so it wins
    always_comb begin
        next_state = state;
        case (state)
            oscp_pkg::ST_RAMP: begin
                // Soft-start still rising, wait for the blanking end
                if (blank_sync) begin
                    next_state = oscp_pkg::ST_RUN; // [R3]
                end
            end
            oscp_pkg::ST_RUN: begin
                // Confirmed short leaves regulation at once
                if (trip) begin
                    next_state = oscp_pkg::ST_FAULT; // [R1]
                end
            end
            oscp_pkg::ST_FAULT: begin
                // Hold break-low until the output is no longer shorted
                if (!below_sync) begin
                    next_state = oscp_pkg::ST_DISCHARGE; // [R7]
                end
            end
            oscp_pkg::ST_DISCHARGE: begin
                // Restart only from an empty soft-start, never mid-ramp
                if (!blank_sync) begin
                    next_state = oscp_pkg::ST_RAMP; // [R7]
                end
            end
            oscp_pkg::ST_OTP: begin
                // Sensor cooled down, go through a fresh soft-start
                if (!ot_sync) begin
                    next_state = oscp_pkg::ST_DISCHARGE; // [R18]
                end
            end
            default: begin
                // Unused codes fall back to a blanked ramp
                next_state = oscp_pkg::ST_RAMP;
            end
        endcase
        // Overtemperature overrides a short or any other state
        if (ot_sync) begin
            next_state = oscp_pkg::ST_OTP; // [R18]
        end
    end

    // Next values of the registered power-stage controls
    logic next_break_low;
    logic next_gate_shutdown;
    logic next_softstart_restart;
    logic next_open_load_enable;

    // Controls follow the next state so outputs line up with it
    always_comb begin
        // Both low-side switches on while the short is handled
        next_break_low = (next_state == oscp_pkg::ST_FAULT)
            || (next_state == oscp_pkg::ST_DISCHARGE); // [R6]
        // Overtemperature stops the drivers outright
        next_gate_shutdown = (next_state == oscp_pkg::ST_OTP); // [R18]
        // Soft-start capacitor held empty until a restart is allowed
        next_softstart_restart = (next_state == oscp_pkg::ST_FAULT)
            || (next_state == oscp_pkg::ST_DISCHARGE)
            || (next_state == oscp_pkg::ST_OTP); // [R7]
        // Open-load check shares the soft-start blanking window
        next_open_load_enable = (next_state == oscp_pkg::ST_RUN); // [R4]
    end

    // Sequencer and control registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Start blanked, as after power-up
            state <= oscp_pkg::ST_RAMP;
            o_break_low <= 1'h0;
            o_gate_shutdown <= 1'h0;
            o_softstart_restart <= 1'h0;
            o_open_load_enable <= 1'h0;
        end else if (i_clk_en) begin
            state <= next_state;
            o_break_low <= next_break_low;
            o_gate_shutdown <= next_gate_shutdown;
            o_softstart_restart <= next_softstart_restart;
            o_open_load_enable <= next_open_load_enable;
        end
    end

    // Flag set request and next flag value
    logic set_flag;
    logic next_short_led_flag;

    // Set wins over a read in the same cycle so no short is lost
    always_comb begin
        set_flag = (state == oscp_pkg::ST_RUN) && trip && !ot_sync; // [R5]
        next_short_led_flag = o_short_led_flag;
        if (i_diag_read_done) begin
            // Completed read of the diagnosis register clears it
            next_short_led_flag = 1'h0; // [R8]
        end
        // Both events in one cycle: the set below wins
        if (set_flag) begin
            next_short_led_flag = 1'h1; // [R5]
        end
    end

    // Flag register, visible in the diagnosis register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // No fault reported out of reset
            o_short_led_flag <= 1'h0;
        end else if (i_clk_en) begin
            o_short_led_flag <= next_short_led_flag;
        end
    end

    // Default level, reset value of the level output
    // Kept as a constant so the reset branch stays constant-only
    localparam logic [oscp_pkg::MV_W-1:0] DEFAULT_MV = oscp_pkg::MV_W'(oscp_pkg::THR_BASE_MV
        + oscp_pkg::THR_STEP_MV * (oscp_pkg::DEFAULT_CODE - 4'h1)); // [R10]
    // Code after the limp-home override
    logic [oscp_pkg::CODE_W-1:0] sel_code;
    // Next values of the threshold outputs
    logic [oscp_pkg::CODE_W-1:0] next_thr_code;
    logic [oscp_pkg::MV_W-1:0] next_thr_mv;
    logic [oscp_pkg::CODE_W-1:0] next_fd_code;

    // Select the applied code and look up its level
    always_comb begin
        // Only chain code and limp state steer the level, not dimming
        sel_code = i_led_chain_code; // [R9] [R13] [R15]
        if (i_limp_home) begin
            // Fail-safe state ignores the programmed code
            sel_code = oscp_pkg::DEFAULT_CODE; // [R12]
        end
        // A new code applies at the next edge; the host must time it
        // against LED switching or a false short can follow
        next_thr_code = sel_code;
        next_thr_mv = thr_table[sel_code]; // [R10] [R11]
        // Fast discharge always follows the written field
        next_fd_code = i_led_chain_code; // [R14]
    end

    // Threshold registers; a code change takes effect one cycle later
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Default level until the first cycle out of reset
            o_short_threshold_code <= oscp_pkg::DEFAULT_CODE;
            o_short_threshold_mv <= DEFAULT_MV;
            o_fast_discharge_code <= oscp_pkg::DEFAULT_CODE;
        end else if (i_clk_en) begin
            o_short_threshold_code <= next_thr_code;
            o_short_threshold_mv <= next_thr_mv;
            o_fast_discharge_code <= next_fd_code;
        end
    end

    // Checks on the sequencer, the flag and the threshold choice
    // All are disabled during reset, none looks at past values

    // Blanking must keep a ramp from going straight to fault
    chk_ramp_blanked: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R3]
        (i_clk_en && state == oscp_pkg::ST_RAMP) |=> (state != oscp_pkg::ST_FAULT))
        else $error("short fault raised during soft-start blanking");

    // Open-load detection stays off while ramping
    chk_open_load_blank: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R4]
        (state == oscp_pkg::ST_RAMP) |-> !o_open_load_enable)
        else $error("open-load detection enabled during ramp");

    // A confirmed short shows in the flag one cycle later
    chk_flag_on_trip: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R5]
        (i_clk_en && set_flag) |=> o_short_led_flag)
        else $error("short flag not set after confirmed short");

    // Fault state always drives break-low
    chk_break_low_fault: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R6]
        (state == oscp_pkg::ST_FAULT) |-> o_break_low)
        else $error("break-low missing in fault state");

    // A diagnosis read clears the flag unless a new short arrives
    chk_flag_clear_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R8]
        (i_clk_en && i_diag_read_done && !set_flag) |=> !o_short_led_flag)
        else $error("short flag survived a diagnosis read");

    // Limp-home applies the default code
    chk_limp_default: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
        (i_clk_en && i_limp_home) |=> (o_short_threshold_code == oscp_pkg::DEFAULT_CODE))
        else $error("limp-home did not force the default code");

    // Overtemperature takes the sequencer from any state
    chk_otp_priority: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R18]
        (i_clk_en && ot_sync) |=> (state == oscp_pkg::ST_OTP))
        else $error("overtemperature did not take priority");

endmodule // oscp_top

//--- test/oscp_far_side.sv
// Far-side model: feedback comparator and soft-start ramp of the power stage
`timescale 1ns/1ps
module oscp_far_side #(
    parameter int RAMP_CYC = 100
) (
    input wire logic i_clk,
    input wire logic i_short,
    input wire logic i_restart,
    output logic o_fb_below = 1'b0,
    output logic o_blank_end = 1'b0
);
    // Soft-start ramp progress in clock cycles
    int ramp = 0;
    // Comparator lags the output by one cycle; restart empties the ramp
    always @(posedge i_clk) begin
        o_fb_below <= i_short;
        if (i_restart) begin
            ramp <= 0;
            o_blank_end <= 1'b0;
        end else if (ramp != RAMP_CYC) begin
            ramp <= ramp + 1;
        end else begin
            o_blank_end <= 1'b1;
        end
    end
endmodule // oscp_far_side

//--- test/oscp_top_tb_top.sv
// Self-checking testbench for the short-circuit protection block
`timescale 1ns/1ps
module oscp_top_tb_top;
    logic clk = 0, rst = 1, en = 1, limp = 0, rd = 0, ot = 0, sh = 0;
    logic below, blank, ssr, flag, brk, gsd, ole;
    logic [3:0] code = 4'h8, thr, fdc;
    logic [10:0] mv;
    int n_fail = 0, n_tests = 0;
    // Clock, 4 ns period
    initial forever #2 clk = ~clk;
    // Power stage: comparator and soft-start, held empty during reset
    oscp_far_side #(.RAMP_CYC(100)) i_far (.i_clk(clk), .i_short(sh), .i_restart(rst || ssr),
        .o_fb_below(below), .o_blank_end(blank));
    oscp_top i_dut (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_fb_below_cmp(below),
        .i_softstart_blank_end(blank), .i_led_chain_code(code), .i_limp_home(limp),
        .i_diag_read_done(rd), .i_overtemp(ot), .o_short_led_flag(flag), .o_break_low(brk),
        .o_gate_shutdown(gsd), .o_softstart_restart(ssr), .o_open_load_enable(ole),
        .o_short_threshold_code(thr), .o_short_threshold_mv(mv), .o_fast_discharge_code(fdc));
    // Compare seen against expected
    task automatic chk(input logic [10:0] v, input logic [10:0] e);
        n_tests++;
        if (v !== e) begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, v, e);
        end
    endtask
    // Drive changes 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #20000;
        n_fail++;
        stop_test;
    end
    initial begin
        cyc(10);
        rst = 0;
        limp = 1;
        code = 4'h3;
        cyc(3);
        chk(11'(thr), 11'h008);
        chk(mv, 11'h233);
        limp = 0;
        // Every code, code 0 is the top level
        for (int c = 0; c < 16; c++) begin
            code = c[3:0];
            cyc(2);
            chk(mv, c == 0 ? 11'h48B : 11'h026 + 11'h04B * 11'(c - 1));
            chk(11'(thr), 11'(c));
            chk(11'(fdc), 11'(c));
        end
        // Clock enable low freezes the applied code
        en = 0;
        code = 4'h2;
        cyc(3);
        chk(11'(thr), 11'h00F);
        en = 1;
        $display("threshold test done");
        // Host code for a 22.8 V short level on a 1/40 divider
        code = 4'((22800 / 40 - 38) / 75 + 1);
        // Short during the ramp is ignored
        sh = 1;
        cyc(40);
        chk(11'(flag), 11'h000);
        chk(11'(ole), 11'h000);
        sh = 0;
        cyc(35);
        chk(11'(ole), 11'h001);
        chk(11'(thr), 11'h008);
        // Six low cycles must not trip, eight in a row must
        sh = 1;
        cyc(6);
        sh = 0;
        cyc(3);
        sh = 1;
        cyc(11);
        chk(11'(flag), 11'h000);
        cyc(1);
        chk(11'(flag), 11'h001);
        chk(11'(brk), 11'h001);
        chk(11'(ole), 11'h000);
        cyc(3);
        chk(11'(ssr), 11'h001);
        sh = 0;
        cyc(10);
        chk(11'(flag), 11'h001);
        chk(11'(brk), 11'h000);
        // Fewer LEDs active, host moves the code along
        code = 4'h5;
        rd = 1;
        cyc(1);
        rd = 0;
        cyc(2);
        chk(11'(flag), 11'h000);
        cyc(100);
        chk(11'(ole), 11'h001);
        chk(mv, 11'h152);
        $display("short test done");
        // Overtemperature with a short present
        ot = 1;
        sh = 1;
        cyc(4);
        chk(11'(gsd), 11'h001);
        cyc(12);
        chk(11'(flag), 11'h000);
        chk(11'(gsd), 11'h001);
        ot = 0;
        sh = 0;
        cyc(6);
        chk(11'(gsd), 11'h000);
        $display("overtemperature test done");
        stop_test;
    end
endmodule // oscp_top_tb_top
